// ### src/block_power_pkg.sv
// Package: register map, field positions, reset values and codes
// for the reset control and block power enable registers.
// Assumes an 8-bit register port with byte-wide offsets.
package block_power_pkg;
  localparam int unsigned ADDR_W                = 5;
  localparam int unsigned DATA_W                = 8;
  localparam logic [4:0]  OFFS_RESET_CONTROL    = 5'h00;
  localparam logic [4:0]  OFFS_BLOCK_POWER      = 5'h01;
  localparam logic [7:0]  RESET_CONTROL_DEFAULT = 8'h00;
  localparam logic [7:0]  BLOCK_POWER_DEFAULT   = 8'hFF;
  localparam logic [7:0]  RESET_MODE_CODE       = 8'h6A;
  localparam logic [7:0]  READ_UNMAPPED         = 8'h00;
  localparam int unsigned BIT_ADC               = 0;
  localparam int unsigned BIT_FIXED_COMP        = 1;
  localparam int unsigned BIT_DAC               = 2;
  localparam int unsigned BIT_AMPLIFIER         = 3;
  localparam int unsigned BIT_BANK_COMP         = 4;
  localparam int unsigned BIT_CURRENT_DISABLE   = 5;
  localparam int unsigned BIT_SENSOR_MUX        = 6;
  localparam int unsigned BIT_CHIP_ENABLE       = 7;
endpackage

// ### src/master_reset_and_function_enable.sv
// Reset control and per-block power enable registers.
// Assumes a synchronous host port: one-cycle strobes, read data next cycle.
// Contract
// - Code 6A holds other registers at defaults
// - Reset mode discards writes to other registers
// - Reset pin clears reset control to 00
// - Host writes 6A then other value
// - Reset control holds written value
// - Power-on and pin reset give 00
// - Power enable defaults to FF after reset
// - Chip enable bit clear means standby
// - Bits 0 to 5 each gate one block, bit 6 gates mux and bank
// - ADC bit powers down only ADC
// - Fixed comparators off, inputs high impedance
// - DAC off, both outputs high impedance
// - Amplifier off, mux no longer reaches ADC
// - Current source bit is active low
// - Mux off, inputs high impedance, bank off
`timescale 1ns/1ps
`default_nettype none

module master_reset_and_function_enable (
  input  wire logic       sys_clk,             // System clock, 100 MHz
  input  wire logic       reset_n,             // Power-on or pin reset, active low
  input  wire logic [4:0] reg_addr,            // Register offset
  input  wire logic [7:0] reg_wdata,           // Write data
  input  wire logic       reg_write,           // Write strobe
  input  wire logic       reg_read,            // Read strobe
  output logic      [7:0] reg_rdata,           // Read data, cycle after strobe
  output logic            reset_mode,          // Other registers held at defaults
  output logic            standby,             // Chip in standby
  output logic            adc_power,           // ADC powered
  output logic            fixed_comp_power,    // Fixed-threshold comparators powered
  output logic            fixed_inputs_hiz,    // Fixed-threshold inputs high impedance
  output logic            dac_power,           // DAC powered
  output logic            dac_outputs_hiz,     // Both DAC outputs high impedance
  output logic            amplifier_power,     // Front-end amplifier powered
  output logic            bank_comp_power,     // Bank comparators powered
  output logic            current_source_power,// Mux current source powered
  output logic            sensor_mux_power,    // Input multiplexer powered
  output logic            universal_inputs_hiz // Multiplexer inputs high impedance
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic [7:0] reset_control;
  logic [7:0] block_power;

  wire        hit_reset   = (reg_addr == block_power_pkg::OFFS_RESET_CONTROL);
  wire        hit_power   = (reg_addr == block_power_pkg::OFFS_BLOCK_POWER);
  wire        in_reset    = (reset_control == block_power_pkg::RESET_MODE_CODE);
  wire        wr_reset    = reg_write && hit_reset;
  // entry forces defaults on the same edge
  // Avoids one stale cycle of readback after entry
  wire        enter_code  = wr_reset && (reg_wdata == block_power_pkg::RESET_MODE_CODE);
  wire        force_def   = in_reset || enter_code;
  wire        wr_power    = reg_write && hit_power && !in_reset;
  wire [7:0]  next_rdata  = !reg_read ? 8'h00 :
                            hit_reset ? reset_control :
                            hit_power ? block_power :
                                        block_power_pkg::READ_UNMAPPED;
  // Power enable derived from the value it will hold next edge
  wire [7:0]  next_power  = wr_power ? reg_wdata : block_power;

  ////////////////////////////////////////////////////////////////////////
  // Reset control register

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_control <= block_power_pkg::RESET_CONTROL_DEFAULT;
    end else if (wr_reset) begin
      reset_control <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block power enable register

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      block_power <= block_power_pkg::BLOCK_POWER_DEFAULT;
    end else if (force_def) begin
      block_power <= block_power_pkg::BLOCK_POWER_DEFAULT;
    end else begin
      block_power <= next_power;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port and registered block controls

  // Outputs track the register one cycle later, from flip-flops
  wire [7:0] eff = in_reset ? block_power_pkg::BLOCK_POWER_DEFAULT : block_power;
  wire       on  = eff[block_power_pkg::BIT_CHIP_ENABLE];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata            <= 8'h00;
      reset_mode           <= 1'b0;
      standby              <= 1'b0;
      adc_power            <= 1'b1;
      fixed_comp_power     <= 1'b1;
      fixed_inputs_hiz     <= 1'b0;
      dac_power            <= 1'b1;
      dac_outputs_hiz      <= 1'b0;
      amplifier_power      <= 1'b1;
      bank_comp_power      <= 1'b1;
      current_source_power <= 1'b0;
      sensor_mux_power     <= 1'b1;
      universal_inputs_hiz <= 1'b0;
    end else begin
      reg_rdata            <= next_rdata;
      reset_mode           <= in_reset;
      standby              <= !on;
      adc_power            <= on && eff[block_power_pkg::BIT_ADC];
      fixed_comp_power     <= on && eff[block_power_pkg::BIT_FIXED_COMP];
      fixed_inputs_hiz     <= !(on && eff[block_power_pkg::BIT_FIXED_COMP]);
      dac_power            <= on && eff[block_power_pkg::BIT_DAC];
      dac_outputs_hiz      <= !(on && eff[block_power_pkg::BIT_DAC]);
      amplifier_power      <= on && eff[block_power_pkg::BIT_AMPLIFIER];
      // mux off also stops bank comparators
      bank_comp_power      <= on && eff[block_power_pkg::BIT_BANK_COMP]
                              && eff[block_power_pkg::BIT_SENSOR_MUX];
      current_source_power <= on && !eff[block_power_pkg::BIT_CURRENT_DISABLE];
      sensor_mux_power     <= on && eff[block_power_pkg::BIT_SENSOR_MUX];
      universal_inputs_hiz <= !(on && eff[block_power_pkg::BIT_SENSOR_MUX]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence enter_reset_mode;
    reg_write && hit_reset && reg_wdata == block_power_pkg::RESET_MODE_CODE;
  endsequence

  a_reset_forces_default: assert property (@(posedge sys_clk) disable iff (!reset_n)
    enter_reset_mode |=> block_power == block_power_pkg::BLOCK_POWER_DEFAULT)
    else $error("power register not forced to default in reset mode");

  a_write_blocked_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
    in_reset |=> block_power == block_power_pkg::BLOCK_POWER_DEFAULT)
    else $error("power register changed during reset mode");

  a_release_accepts_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    enter_reset_mode ##1 (wr_reset && reg_wdata != block_power_pkg::RESET_MODE_CODE)
    ##1 (reg_write && hit_power) |=> block_power == $past(reg_wdata))
    else $error("write not accepted after leaving reset mode");

  a_control_holds_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !wr_reset |=> $stable(reset_control))
    else $error("reset control changed without a write");

  a_readback_stored: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_read && hit_reset |=> reg_rdata == $past(reset_control))
    else $error("reset control readback wrong");

  a_readback_power: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_read && hit_power |=> reg_rdata == $past(block_power))
    else $error("power register readback wrong");

  a_standby_follows_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && !block_power[block_power_pkg::BIT_CHIP_ENABLE] |=> standby && !adc_power)
    else $error("standby not entered on cleared chip enable");

  a_current_active_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && on && block_power[block_power_pkg::BIT_CURRENT_DISABLE] |=> !current_source_power)
    else $error("current source on while disable bit set");

  a_mux_stops_bank: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && !block_power[block_power_pkg::BIT_SENSOR_MUX] |=> !bank_comp_power && universal_inputs_hiz)
    else $error("bank comparators on with multiplexer off");

  a_dac_outputs_hiz: assert property (@(posedge sys_clk) disable iff (!reset_n)
    dac_outputs_hiz == !dac_power)
    else $error("DAC outputs not high impedance when DAC off");

  a_fixed_inputs_hiz: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && on && !block_power[block_power_pkg::BIT_FIXED_COMP]
    |=> fixed_inputs_hiz && !fixed_comp_power && bank_comp_power == $past(eff[4] && eff[6]))
    else $error("fixed comparator power down wrong");

  a_adc_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && on && block_power[7:1] == 7'h7F && !block_power[0]
    |=> !adc_power && amplifier_power && sensor_mux_power)
    else $error("ADC power down affected other blocks");

  a_amp_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && on && !block_power[block_power_pkg::BIT_AMPLIFIER] && block_power[4] && block_power[6]
    |=> !amplifier_power && bank_comp_power)
    else $error("amplifier power down wrong");

  ////////////////////////////////////////////////////////////////////////
  // Checks: entering and leaving reset mode

  sequence leave_reset_mode;
    wr_reset && reg_wdata != block_power_pkg::RESET_MODE_CODE;
  endsequence

  sequence power_write;
    reg_write && hit_power && !in_reset;
  endsequence

  a_entry_sets_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    enter_reset_mode |=> in_reset ##1 reset_mode)
    else $error("reset mode not entered after code write");

  a_release_normal: assert property (@(posedge sys_clk) disable iff (!reset_n)
    enter_reset_mode ##1 leave_reset_mode |=> !in_reset ##1 !reset_mode)
    else $error("reset mode not left after other value");

  a_reset_mode_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
    in_reset |=> reset_mode)
    else $error("reset mode flag low while code stored");

  a_normal_mode_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> !reset_mode)
    else $error("reset mode flag high in normal operation");

  a_reset_mode_powers: assert property (@(posedge sys_clk) disable iff (!reset_n)
    in_reset |=> !standby && adc_power && fixed_comp_power && dac_power && amplifier_power
    && bank_comp_power && sensor_mux_power && !current_source_power)
    else $error("block powers not at defaults in reset mode");

  a_reset_mode_hiz_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    in_reset |=> !fixed_inputs_hiz && !dac_outputs_hiz && !universal_inputs_hiz)
    else $error("pins high impedance in reset mode");

  a_reset_read_default: assert property (@(posedge sys_clk) disable iff (!reset_n)
    in_reset && reg_read && hit_power |=> reg_rdata == block_power_pkg::BLOCK_POWER_DEFAULT)
    else $error("power register reads non-default in reset mode");

  a_release_defaults: assert property (@(posedge sys_clk)
    $rose(reset_n) |-> reset_control == block_power_pkg::RESET_CONTROL_DEFAULT
    && block_power == block_power_pkg::BLOCK_POWER_DEFAULT && !reset_mode && !standby)
    else $error("registers not at defaults when reset released");

  ////////////////////////////////////////////////////////////////////////
  // Checks: storage and readback

  a_control_write_lands: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_reset |=> reset_control == $past(reg_wdata))
    else $error("reset control write not stored");

  a_power_write_lands: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_power |=> block_power == $past(reg_wdata))
    else $error("power register write not stored");

  a_power_holds_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && !reg_write |=> $stable(block_power))
    else $error("power register changed without a write");

  a_write_then_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_write ##1 !reg_write ##1 (reg_read && hit_power) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("power register readback differs from write");

  a_read_idle_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");

  a_read_unmapped: assert property (@(posedge sys_clk) disable iff (!reset_n)
    reg_read && !hit_reset && !hit_power |=> reg_rdata == block_power_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////
  // Checks: block controls in normal operation

  a_standby_released: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && block_power[block_power_pkg::BIT_CHIP_ENABLE] |=> !standby)
    else $error("standby with chip enable set");

  a_standby_all_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && !block_power[block_power_pkg::BIT_CHIP_ENABLE] |=> !fixed_comp_power && !dac_power
    && !amplifier_power && !bank_comp_power && !current_source_power && !sensor_mux_power)
    else $error("block powered in standby");

  a_adc_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> adc_power == $past(on && block_power[block_power_pkg::BIT_ADC]))
    else $error("ADC power does not follow its bit");

  a_fixed_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> fixed_comp_power == $past(on && block_power[block_power_pkg::BIT_FIXED_COMP]))
    else $error("fixed comparator power does not follow its bit");

  a_fixed_hiz_follows: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> fixed_inputs_hiz == !$past(on && block_power[block_power_pkg::BIT_FIXED_COMP]))
    else $error("fixed inputs high impedance wrong");

  a_dac_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && on && !block_power[block_power_pkg::BIT_DAC] |=> !dac_power && dac_outputs_hiz)
    else $error("DAC not off with its bit clear");

  a_dac_hiz_follows: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> dac_outputs_hiz == !$past(on && block_power[block_power_pkg::BIT_DAC]))
    else $error("DAC outputs high impedance wrong");

  a_amp_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> amplifier_power == $past(on && block_power[block_power_pkg::BIT_AMPLIFIER]))
    else $error("amplifier power does not follow its bit");

  a_bank_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> bank_comp_power == $past(on && block_power[block_power_pkg::BIT_BANK_COMP]
    && block_power[block_power_pkg::BIT_SENSOR_MUX]))
    else $error("bank comparator power wrong");

  a_mux_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> sensor_mux_power == $past(on && block_power[block_power_pkg::BIT_SENSOR_MUX]))
    else $error("multiplexer power does not follow its bit");

  a_mux_hiz_follows: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> universal_inputs_hiz == !$past(on && block_power[block_power_pkg::BIT_SENSOR_MUX]))
    else $error("multiplexer inputs high impedance wrong");

  a_mux_inputs_hiz: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && on && !block_power[block_power_pkg::BIT_SENSOR_MUX]
    |=> universal_inputs_hiz && fixed_comp_power == $past(block_power[block_power_pkg::BIT_FIXED_COMP]))
    else $error("multiplexer off disturbed fixed comparators");

  a_current_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && on && !block_power[block_power_pkg::BIT_CURRENT_DISABLE] |=> current_source_power)
    else $error("current source off with disable bit clear");

  a_current_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset |=> current_source_power == $past(on && !block_power[block_power_pkg::BIT_CURRENT_DISABLE]))
    else $error("current source does not follow its bit");

  a_adc_keeps_others: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !in_reset && on && !block_power[block_power_pkg::BIT_ADC]
    |=> fixed_comp_power == $past(block_power[block_power_pkg::BIT_FIXED_COMP])
    && sensor_mux_power == $past(block_power[block_power_pkg::BIT_SENSOR_MUX]))
    else $error("ADC power down disturbed other blocks");

endmodule // master_reset_and_function_enable

`default_nettype wire

// ### test/host_model.sv
// Host controller model: register port master with write and read tasks.
// Assumes one clock, strobes sampled on its rising edge, read data one cycle later.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic       sys_clk,   // System clock
  output var  logic [4:0] reg_addr,  // Register offset
  output var  logic [7:0] reg_wdata, // Write data
  output var  logic       reg_write, // Write strobe
  output var  logic       reg_read,  // Read strobe
  input  wire logic [7:0] reg_rdata  // Read data
);
  initial begin
    reg_addr  = 5'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle strobes except in reset_then_write, which holds its strobe for three; signals change only right after an edge
  task automatic write(input logic [4:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // enter with the code, leave with another, then write
  // Strobe held across three back-to-back writes
  task automatic reset_then_write(input logic [7:0] release_code, input logic [7:0] power);
    @(posedge sys_clk);
    reg_addr  <= 5'h00;
    reg_wdata <= 8'h6A;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_wdata <= release_code;
    @(posedge sys_clk);
    reg_addr  <= 5'h01;
    reg_wdata <= power;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // Data is taken in the cycle after the strobe, its only valid cycle
  task automatic read(input logic [4:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 data = reg_rdata;
  endtask
endmodule // host_model

`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the reset control and block power registers.
// Assumes host_model as bus master and controls one cycle behind a write.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  wire  [4:0]  reg_addr;
  wire  [7:0]  reg_wdata;
  wire         reg_write;
  wire         reg_read;
  wire  [7:0]  reg_rdata;
  wire  [11:0] ctl;
  logic [7:0]  rd;
  logic [7:0]  v;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #5 sys_clk = ~sys_clk;

  host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

  master_reset_and_function_enable i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reset_mode(ctl[11]), .standby(ctl[10]), .adc_power(ctl[9]),
    .fixed_comp_power(ctl[8]), .fixed_inputs_hiz(ctl[7]), .dac_power(ctl[6]),
    .dac_outputs_hiz(ctl[5]), .amplifier_power(ctl[4]), .bank_comp_power(ctl[3]),
    .current_source_power(ctl[2]), .sensor_mux_power(ctl[1]), .universal_inputs_hiz(ctl[0]));

  ////////////////////////////////////////////////////////////////////////////
  // Expected control outputs; reset mode is modelled by the caller passing FF
  function automatic logic [11:0] ctl_of(input logic [7:0] val, input logic rm);
    logic c;
    c = val[7];
    return {rm, ~c, c & val[0], c & val[1], ~(c & val[1]), c & val[2], ~(c & val[2]),
            c & val[3], c & val[4] & val[6], c & ~val[5], c & val[6], ~(c & val[6])};
  endfunction

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_check(input logic [4:0] addr, input logic [7:0] exp, input string name);
    i_host.read(addr, rd);
    check(name, {4'h0, rd}, {4'h0, exp});
  endtask

  task automatic ctl_check(input logic [7:0] val, input logic rm);
    @(posedge sys_clk);
    #1 check("controls", ctl, ctl_of(val, rm));
  endtask

  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    reg_check(5'h00, 8'h00, "reset_control");
    reg_check(5'h01, 8'hFF, "block_power_enable");
    ctl_check(8'hFF, 1'b0);
    // Clear one enable bit at a time, bit 7 last for standby
    for (int i = 0; i < 8; i++) begin
      v = 8'hFF ^ (8'h01 << i);
      i_host.write(5'h01, v);
      ctl_check(v, 1'b0);
      reg_check(5'h01, v, "block_power_enable");
    end
    i_host.write(5'h00, 8'h6A);
    ctl_check(8'hFF, 1'b1);
    reg_check(5'h00, 8'h6A, "reset_control");
    i_host.write(5'h01, 8'h00);
    reg_check(5'h01, 8'hFF, "block_power_enable");
    i_host.write(5'h00, 8'hFF);
    i_host.write(5'h01, 8'h55);
    ctl_check(8'h55, 1'b0);
    reg_check(5'h01, 8'h55, "block_power_enable");
    reg_check(5'h00, 8'hFF, "reset_control");
    // Unmapped offset: write dropped, read returns zero
    i_host.write(5'h1F, 8'hA5);
    reg_check(5'h1F, 8'h00, "unmapped");
    reg_check(5'h01, 8'h55, "block_power_enable");
    // Back-to-back reset sequence, read straight after
    i_host.reset_then_write(8'h3C, 8'hE5);
    reg_check(5'h01, 8'hE5, "block_power_enable");
    reg_check(5'h00, 8'h3C, "reset_control");
    ctl_check(8'hE5, 1'b0);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    // host sees 00, so enable register tells power
    reg_check(5'h00, 8'h00, "reset_control");
    reg_check(5'h01, 8'hFF, "block_power_enable");
    ctl_check(8'hFF, 1'b0);
    finish_test();
  end
endmodule // testbench

`default_nettype wire
